// ---- hw/ntc_pkg.sv ----
// package for the timekeeping sram block: map, field positions, timing
// assumes a 20 MHz core clock and a 32768 Hz crystal tick sampled as a pin
package ntc_pkg;
    // ------------------------------------------------------------
    // map
    // ------------------------------------------------------------
    localparam int          ADDR_W     = 19;
    localparam int          DATA_W     = 8;
    localparam logic [18:0] CLK_BASE   = 19'h7FFF8; // control byte
    localparam logic [2:0]  IDX_CTRL   = 3'h0;
    localparam logic [2:0]  IDX_SEC    = 3'h1;
    localparam logic [2:0]  IDX_MIN    = 3'h2;
    localparam logic [2:0]  IDX_HOUR   = 3'h3;
    localparam logic [2:0]  IDX_DAY    = 3'h4;
    localparam logic [2:0]  IDX_DATE   = 3'h5;
    localparam logic [2:0]  IDX_MONTH  = 3'h6;
    localparam logic [2:0]  IDX_YEAR   = 3'h7;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int          LOAD_BIT   = 7; // time_load_bit
    localparam int          HOLD_BIT   = 6; // snapshot_hold_bit
    localparam int          STOP_BIT   = 7; // stop_count_bit in seconds
    localparam int          PROBE_BIT  = 6; // half_khz_probe_bit in day
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    // ------------------------------------------------------------
    // timing: crystal ticks
    // ------------------------------------------------------------
    localparam int          XTAL_HZ    = 32768;
    localparam int          PROBE_HZ   = 512;
    localparam int          PROBE_DIV  = XTAL_HZ / (2 * PROBE_HZ); // ticks per toggle
    localparam logic [15:0] SEC_LAST   = 16'(XTAL_HZ - 1);

    // time set carried as one word
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } ntc_time_t;
endpackage : ntc_pkg

// ---- hw/ntc_top.sv ----
// nonvolatile sram with clock in the top eight bytes, sram-style host port
// assumes host pins and crystal tick are asynchronous, sampled on clk
`timescale 1ns/100ps
module ntc_top #(
    parameter int DEPTH   = 524288,
    parameter int XTAL_HZ = ntc_pkg::XTAL_HZ
) (
    // system
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // host sram port
    input  wire logic [18:0]          locationInputs,
    input  wire logic                 chipSel_n,
    input  wire logic                 outDrive_n,
    input  wire logic                 writeStrobe_n,
    input  wire logic [7:0]           dataLinesIn,
    output logic      [7:0]           dataLinesOut,
    output logic                      dataLinesOe_n,
    // supply monitor and fail pin
    input  wire logic                 supplyLow,
    output logic                      supplyFailOut,
    output logic                      supplyFailOe_n,
    // crystal tick (crystal_pins oscillator output)
    input  wire logic                 crystalTick
);
    // crystal-derived counts; the probe divider must be a power of two
    localparam int          PDIV       = XTAL_HZ / (2 * ntc_pkg::PROBE_HZ);
    localparam logic [15:0] SEC_LAST_P = 16'(XTAL_HZ - 1);
    localparam logic [15:0] PDIV_MASK  = 16'(PDIV - 1);
    initial begin
        if (DEPTH != 524288) $error("ntc_top: DEPTH must be 512k");
        if (XTAL_HZ < 2 * ntc_pkg::PROBE_HZ || XTAL_HZ > 65536 ||
            XTAL_HZ % (2 * ntc_pkg::PROBE_HZ) != 0 || (PDIV & (PDIV - 1)) != 0) begin
            $error("ntc_top: XTAL_HZ must be a power-of-two multiple of 1024 up to 65536");
        end
    end

    // ------------------------------------------------------------
    // pin sampling: three flops, change taken when 2nd and 3rd agree
    // ------------------------------------------------------------
    localparam int NS = 5;
    logic [NS-1:0] s1, s2, s3, pin;
    wire  [NS-1:0] rawPins = {chipSel_n, outDrive_n, writeStrobe_n, supplyLow, crystalTick};
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= 5'h1C; // idle levels, so no false fail or edge
            s2 <= 5'h1C;
            s3 <= 5'h1C;
        end else begin
            s1 <= rawPins;
            s2 <= s1;
            s3 <= s2;
        end
    end
    // filtered levels; selects idle high, supply low idle low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin <= 5'h1C;
        end else begin
            for (int i = 0; i < NS; i++) begin
                if (s2[i] == s3[i]) pin[i] <= s3[i];
            end
        end
    end
    logic [18:0] addrQ, addr;
    logic [7:0]  dinQ, din;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addrQ <= 19'h00000;
            addr  <= 19'h00000;
            dinQ  <= 8'h00;
            din   <= 8'h00;
        end else begin
            addrQ <= locationInputs;
            addr  <= addrQ;
            dinQ  <= dataLinesIn;
            din   <= dinQ;
        end
    end
    wire csN = pin[4], oeN = pin[3], weN = pin[2], fail = pin[1], xt = pin[0];

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    wire sel     = !csN && !fail;
    wire isClk   = (addr[18:3] == ntc_pkg::CLK_BASE[18:3]);
    wire [2:0] idx = addr[2:0];
    logic weD;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) weD <= 1'b0;
        else         weD <= sel && !weN;
    end
    wire wrNow  = sel && !weN;
    wire wrEnd  = weD && !wrNow && !fail;                 // commit at strobe end

    // ------------------------------------------------------------
    // memory below the clock
    // ------------------------------------------------------------
    logic [7:0] mem [0:DEPTH-1];
    logic [7:0] memQ;
    always_ff @(posedge clk) begin
        if (wrNow && !isClk) mem[addr] <= din;
        memQ <= mem[addr];
    end

    // ------------------------------------------------------------
    // control bits shared by the tick and register logic
    // ------------------------------------------------------------
    ntc_pkg::ntc_time_t cnt, vis;
    logic [7:0]  ctrl;
    logic        loadD;
    logic        run;
    wire hold  = ctrl[ntc_pkg::HOLD_BIT];
    wire load  = ctrl[ntc_pkg::LOAD_BIT];
    assign run = !vis.second[ntc_pkg::STOP_BIT];
    wire loadFall = loadD && !load;

    // ------------------------------------------------------------
    // crystal second and probe ticks
    // ------------------------------------------------------------
    logic        xtD;
    logic [15:0] subCnt;
    logic        probe;
    wire  xtEdge = xt && !xtD && run;
    wire  secTick = xtEdge && subCnt == SEC_LAST_P && !loadFall;
    // divider restarts when a load ends, so the first loaded second is whole
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            xtD    <= 1'b0;
            subCnt <= 16'h0000;
            probe  <= 1'b0;
        end else begin
            xtD <= xt;
            if (loadFall) begin
                subCnt <= 16'h0000;
            end else if (xtEdge) begin
                subCnt <= secTick ? 16'h0000 : subCnt + 16'h0001;
                if ((subCnt & PDIV_MASK) == PDIV_MASK) probe <= !probe;
            end
        end
    end

    // ------------------------------------------------------------
    // bcd helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction : bcdInc
    function automatic logic [7:0] monthLast(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = (y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                     : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8));
        unique case (m)
            8'h02:                      monthLast = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: monthLast = 8'h30;
            default:                    monthLast = 8'h31;
        endcase
    endfunction : monthLast

    // ------------------------------------------------------------
    // control, visible and counting registers
    // ------------------------------------------------------------
    // control byte: hold and load bits, load edge detect
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl  <= ntc_pkg::CTRL_RESET;
            loadD <= 1'b0;
        end else begin
            loadD <= load;
            if (wrEnd && isClk && idx == ntc_pkg::IDX_CTRL) ctrl <= din;
        end
    end

    // counting registers advance each second, stalled while the load bit is set but never by hold
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
        end else if (loadFall) begin
            cnt <= vis;
        end else if (secTick && !load) begin
            cnt.second <= bcdInc(cnt.second);
            if (cnt.second[6:0] == 7'h59) begin
                cnt.second <= 8'h00;
                cnt.minute <= bcdInc(cnt.minute);
                if (cnt.minute == 8'h59) begin
                    cnt.minute <= 8'h00;
                    cnt.hour   <= bcdInc(cnt.hour);
                    if (cnt.hour == 8'h23) begin
                        cnt.hour <= 8'h00;
                        cnt.day  <= (cnt.day[2:0] == 3'h7) ? {cnt.day[7:3], 3'h1}
                                                           : bcdInc(cnt.day);
                        cnt.date <= bcdInc(cnt.date);
                        if (cnt.date == monthLast(cnt.month, cnt.year)) begin
                            cnt.date  <= 8'h01;
                            cnt.month <= bcdInc(cnt.month);
                            if (cnt.month == 8'h12) begin
                                cnt.month <= 8'h01;
                                cnt.year  <= (cnt.year == 8'h99) ? 8'h00 : bcdInc(cnt.year);
                            end
                        end
                    end
                end
            end
        end
    end

    // visible registers: host writes, snapshot copy at tick or hold release
    logic holdD;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) holdD <= 1'b0;
        else         holdD <= hold;
    end
    wire refresh = !hold && !load && (secTick || holdD);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vis <= '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
        end else if (wrEnd && isClk && idx != ntc_pkg::IDX_CTRL) begin
            unique case (idx)
                ntc_pkg::IDX_SEC:   vis.second <= din;
                ntc_pkg::IDX_MIN:   vis.minute <= din;
                ntc_pkg::IDX_HOUR:  vis.hour   <= din;
                ntc_pkg::IDX_DAY:   vis.day    <= din;
                ntc_pkg::IDX_DATE:  vis.date   <= din;
                ntc_pkg::IDX_MONTH: vis.month  <= din;
                default:            vis.year   <= din;
            endcase
        end else if (refresh) begin
            vis <= '{cnt.year, cnt.month, cnt.date, cnt.day, cnt.hour, cnt.minute,
                     {vis.second[ntc_pkg::STOP_BIT], cnt.second[6:0]}};
        end
    end

    // ------------------------------------------------------------
    // read data and pin drive
    // ------------------------------------------------------------
    logic [7:0] clkRd;
    always_comb begin
        unique case (idx)
            ntc_pkg::IDX_CTRL:  clkRd = ctrl;
            ntc_pkg::IDX_SEC:   clkRd = (vis.day[ntc_pkg::PROBE_BIT] && run)
                                        ? {vis.second[7:1], probe} : vis.second;
            ntc_pkg::IDX_MIN:   clkRd = vis.minute;
            ntc_pkg::IDX_HOUR:  clkRd = vis.hour;
            ntc_pkg::IDX_DAY:   clkRd = vis.day;
            ntc_pkg::IDX_DATE:  clkRd = vis.date;
            ntc_pkg::IDX_MONTH: clkRd = vis.month;
            default:            clkRd = vis.year;
        endcase
    end
    wire rdDrive = sel && weN && !oeN;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dataLinesOut   <= 8'h00;
            dataLinesOe_n  <= 1'b1;
            supplyFailOut  <= 1'b0;
            supplyFailOe_n <= 1'b1;
        end else begin
            dataLinesOut   <= isClk ? clkRd : memQ;
            dataLinesOe_n  <= !rdDrive;
            supplyFailOut  <= 1'b0;
            supplyFailOe_n <= !fail;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    float_deselect_a: assert property (@(posedge clk) disable iff (!arst_n)
        (csN || fail) |=> dataLinesOe_n) else $error("data driven while deselected");
    fail_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
        fail |=> !supplyFailOe_n) else $error("fail pin not pulled");
    no_write_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
        fail |-> !wrNow) else $error("write during supply fail");
    hold_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
        (hold && $past(hold) && !wrEnd) |=> $stable(vis))
        else $error("visible changed in hold");
    load_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
        loadFall |=> cnt.hour == $past(vis.hour)) else $error("load not copied");
    tick_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
        (secTick && !hold && !load && !wrEnd) |=> vis.minute == $past(cnt.minute))
        else $error("no copy on tick");
    count_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (secTick && hold && !load) |=> cnt.second != $past(cnt.second))
        else $error("counter stalled in hold");
    write_oe_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wrNow && !oeN) |=> dataLinesOe_n) else $error("driving during write");

    // end of a day: the last second of 23:59:59 is counted
    wire dayEnd = secTick && !load && cnt.second[6:0] == 7'h59
                  && cnt.minute == 8'h59 && cnt.hour == 8'h23;

    // no clock commit once the supply is reported low
    commit_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
        fail |-> !wrEnd) else $error("clock write committed in supply fail");
    // read with output control low turns the drivers on
    read_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
        (sel && weN && !oeN) |=> !dataLinesOe_n) else $error("read data not driven");
    // fail pin released once the supply is good
    fail_release_a: assert property (@(posedge clk) disable iff (!arst_n)
        !fail |=> supplyFailOe_n) else $error("fail pin held without fail");
    // load bit freezes the visible set apart from host writes
    load_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
        (load && !wrEnd) |=> $stable(vis)) else $error("visible changed in load");
    // hold release copies the counting set at once, checked on hour, date and year
    release_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
        (holdD && !hold && !load && !wrEnd) |=> (vis.hour == $past(cnt.hour)
        && vis.date == $past(cnt.date) && vis.year == $past(cnt.year)))
        else $error("no refresh on hold release");
    // a committed minute write lands in the visible minute
    minute_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wrEnd && isClk && idx == ntc_pkg::IDX_MIN) |=> vis.minute == $past(din))
        else $error("minute write lost");
    // a memory write stores the sampled data byte
    mem_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wrNow && !isClk) |=> mem[$past(addr)] == $past(din))
        else $error("memory write lost");
    // a stopped oscillator freezes divider and probe
    stop_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!run && !loadFall) |=> ($stable(subCnt) && $stable(probe)))
        else $error("divider moved while stopped");
    // 23:59:59 wraps to midnight
    day_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
        dayEnd |=> (cnt.hour == 8'h00 && cnt.minute == 8'h00 && cnt.second[6:0] == 7'h00))
        else $error("no wrap at midnight");
endmodule : ntc_top

// ---- tb/ntc_host_model.sv ----
// host model: drives the sram-style pins of the timekeeping block
// assumes the bench resolves the data wire and hands it back as dataWire
`timescale 1ns/100ps
module ntc_host_model (
    // system
    input  wire logic        clk,
    // pins toward the device
    output logic      [18:0] locationInputs,
    output logic             chipSel_n,
    output logic             outDrive_n,
    output logic             writeStrobe_n,
    output logic             hostDrive,
    output logic      [7:0]  hostData,
    // resolved wire and device drive state
    input  wire logic [7:0]  dataWire,
    input  wire logic        devOe_n
);
    // idle bus at time zero
    initial begin
        locationInputs = 19'h00000;
        chipSel_n = 1'b1;
        outDrive_n = 1'b1;
        writeStrobe_n = 1'b1;
        hostDrive = 1'b0;
        hostData = 8'h00;
    end

    // write cycle: strobe low eight cycles, data held past the rise
    task automatic write_byte(input logic [18:0] addr, input logic [7:0] d, input logic cs,
                              input logic od);
        @(negedge clk);
        locationInputs = addr;
        hostData = d;
        hostDrive = 1'b1;
        chipSel_n = cs;
        outDrive_n = od;
        writeStrobe_n = 1'b0;
        repeat (8) @(negedge clk);
        writeStrobe_n = 1'b1;
        repeat (6) @(negedge clk);
        chipSel_n = 1'b1;
        outDrive_n = 1'b1;
        hostDrive = 1'b0;
        repeat (3) @(negedge clk);
    endtask : write_byte

    // read cycle: sample once the filtered pins have settled
    task automatic read_byte(input logic [18:0] addr, input logic cs, input logic od,
                             output logic [7:0] d, output logic oe);
        @(negedge clk);
        locationInputs = addr;
        chipSel_n = cs;
        outDrive_n = od;
        repeat (10) @(negedge clk);
        d = dataWire;
        oe = devOe_n;
        chipSel_n = 1'b1;
        outDrive_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask : read_byte

    // sustained read, counting changes of data bit 0
    task automatic count_toggles(input logic [18:0] addr, output int n);
        logic prev;
        n = 0;
        @(negedge clk);
        locationInputs = addr;
        chipSel_n = 1'b0;
        outDrive_n = 1'b0;
        repeat (10) @(negedge clk);
        prev = dataWire[0];
        repeat (1600) begin
            @(negedge clk);
            if (dataWire[0] !== prev) n++;
            prev = dataWire[0];
        end
        chipSel_n = 1'b1;
        outDrive_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask : count_toggles
endmodule : ntc_host_model

// ---- tb/ntc_top_tb_top.sv ----
// self-checking bench for the timekeeping sram block
// assumes the package, the design and the host model are compiled first
`timescale 1ns/100ps
module ntc_top_tb_top;
    localparam logic [18:0] CB = ntc_pkg::CLK_BASE;
    localparam int          XT_HZ = 2048; // sped-up crystal so a second fits in the run
    logic [18:0] locationInputs;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        supplyLow = 1'b0;
    logic        crystalTick = 1'b0;
    logic        chipSel_n, outDrive_n, writeStrobe_n, hostDrive;
    logic [7:0]  hostData, dataLinesOut, dataWire;
    logic        dataLinesOe_n, supplyFailOut, supplyFailOe_n, failPin;
    logic [7:0]  tval [8];
    int          fails = 0;
    int          checkCount = 0;
    int          cycles = 0;

    // data wire: host, device, or a changing pattern when nobody drives
    assign dataWire = hostDrive ? hostData : (!dataLinesOe_n ? dataLinesOut : 8'hA5 ^ {8{clk}});
    // open-drain fail pin with external pull-up
    assign failPin = supplyFailOe_n ? 1'b1 : supplyFailOut;

    ntc_top #(.XTAL_HZ(XT_HZ)) DUT (.clk(clk), .arst_n(arst_n),
        .locationInputs(locationInputs),
        .chipSel_n(chipSel_n), .outDrive_n(outDrive_n), .writeStrobe_n(writeStrobe_n),
        .dataLinesIn(dataWire), .dataLinesOut(dataLinesOut), .dataLinesOe_n(dataLinesOe_n),
        .supplyLow(supplyLow), .supplyFailOut(supplyFailOut),
        .supplyFailOe_n(supplyFailOe_n), .crystalTick(crystalTick));
    ntc_host_model host (.clk(clk), .locationInputs(locationInputs), .chipSel_n(chipSel_n),
        .outDrive_n(outDrive_n), .writeStrobe_n(writeStrobe_n), .hostDrive(hostDrive),
        .hostData(hostData), .dataWire(dataWire), .devOe_n(dataLinesOe_n));

    // 20 MHz core clock
    initial forever #25 clk = ~clk;
    // fast crystal stand-in: one tick every ten core cycles
    initial forever begin
        repeat (5) @(negedge clk);
        crystalTick = ~crystalTick;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    // load mode, time bytes written, load cleared
    task automatic load_time();
        host.write_byte(CB, 8'h80, 1'b0, 1'b1);
        for (int i = 1; i < 8; i++) host.write_byte(CB + 19'(i), tval[i], 1'b0, 1'b1);
        host.write_byte(CB, 8'h00, 1'b0, 1'b1);
    endtask : load_time

    // hold, then compare every time byte with tval
    task automatic compare_time();
        logic [7:0] d;
        logic       oe;
        host.write_byte(CB, 8'h40, 1'b0, 1'b1);
        for (int i = 1; i < 8; i++) begin
            host.read_byte(CB + 19'(i), 1'b0, 1'b0, d, oe);
            check("time byte", d, tval[i]);
        end
        host.read_byte(CB, 1'b0, 1'b0, d, oe);
        check("control byte", d, 8'h40);
    endtask : compare_time

    task automatic t_reset_values();
        logic [7:0] expv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
        logic [7:0] d;
        logic       oe;
        for (int i = 0; i < 8; i++) begin
            host.read_byte(CB + 19'(i), 1'b0, 1'b0, d, oe);
            check("clock reset byte", d, expv[i]);
            check("read drive", {7'h00, oe}, 8'h00);
        end
    endtask : t_reset_values

    task automatic t_sram();
        logic [18:0] adr [3] = '{19'h00000, 19'h12345, 19'h7FFF7};
        logic [7:0]  d;
        logic        oe;
        for (int i = 0; i < 3; i++) host.write_byte(adr[i], 8'h3C ^ 8'(i), 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            host.read_byte(adr[i], 1'b0, 1'b0, d, oe);
            check("sram byte", d, 8'h3C ^ 8'(i));
        end
    endtask : t_sram

    task automatic t_deselect();
        logic [7:0] d;
        logic       oe;
        host.read_byte(19'h00000, 1'b0, 1'b1, d, oe);
        check("float with output off", {7'h00, oe}, 8'h01);
        host.write_byte(19'h00000, 8'hFF, 1'b1, 1'b1);
        host.read_byte(19'h00000, 1'b1, 1'b0, d, oe);
        check("float when deselected", {7'h00, oe}, 8'h01);
        host.read_byte(19'h00000, 1'b0, 1'b0, d, oe);
        check("no write when deselected", d, 8'h3C);
    endtask : t_deselect

    task automatic t_supply();
        logic [7:0] d;
        logic       oe;
        @(negedge clk);
        supplyLow = 1'b1;
        repeat (8) @(negedge clk);
        check("fail pin in fail", {7'h00, failPin}, 8'h00);
        host.write_byte(19'h00000, 8'h99, 1'b0, 1'b1);
        host.read_byte(19'h00000, 1'b0, 1'b0, d, oe);
        check("float in supply fail", {7'h00, oe}, 8'h01);
        supplyLow = 1'b0;
        repeat (8) @(negedge clk);
        check("fail pin released", {7'h00, failPin}, 8'h01);
        host.read_byte(19'h00000, 1'b0, 1'b0, d, oe);
        check("no write in supply fail", d, 8'h3C);
    endtask : t_supply

    task automatic t_load();
        logic [7:0] d;
        logic       oe;
        tval = '{8'h00, 8'h59, 8'h59, 8'h23, 8'h04, 8'h29, 8'h02, 8'h24};
        load_time();
        compare_time();
        // one full second passes while the hold is set
        repeat (20600) @(negedge clk);
        host.read_byte(CB + 19'(ntc_pkg::IDX_SEC), 1'b0, 1'b0, d, oe);
        check("seconds frozen in hold", d, 8'h59);
        host.write_byte(CB, 8'h00, 1'b0, 1'b1);
        repeat (10000) @(negedge clk);
        tval = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h03, 8'h24};
        compare_time();
    endtask : t_load

    task automatic t_probe();
        int n;
        int exp;
        exp = 1600 / ((XT_HZ / (2 * ntc_pkg::PROBE_HZ)) * 10);
        tval[4] = 8'h44;
        load_time();
        host.count_toggles(CB + 19'(ntc_pkg::IDX_SEC), n);
        check("probe toggles in range", 8'(n >= exp - 1 && n <= exp + 1), 8'h01);
        tval[1] = 8'h80;
        load_time();
        host.count_toggles(CB + 19'(ntc_pkg::IDX_SEC), n);
        check("toggles while stopped", 8'(n), 8'h00);
    endtask : t_probe

    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset_values();
        t_sram();
        t_deselect();
        t_supply();
        t_load();
        t_probe();
        give_verdict();
    end
endmodule : ntc_top_tb_top
